// ==== pkg/dual_timer_params.svh ====
// Purpose: register offsets, bit positions, reset values and mode codes for the dual timer
// Assumes: byte-wide special-function register port
// Notes: definitions only
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define OFF_TIMER_CONTROL 8'h88
`define OFF_TIMER_MODE 8'h89
`define OFF_T0_LOW 8'h8A
`define OFF_T1_LOW 8'h8B
`define OFF_T0_HIGH 8'h8C
`define OFF_T1_HIGH 8'h8D
`define BIT_TF1 7
`define BIT_TR1 6
`define BIT_TF0 5
`define BIT_TR0 4
`define BIT_IE1 3
`define BIT_IT1 2
`define BIT_IE0 1
`define BIT_IT0 0
`define MOD_TIMER_ONE_GATE_SELECT 7
`define MOD_CT1 6
`define MOD_TIMER_ZERO_GATE_SELECT 3
`define MOD_CT0 2
`define RESET_BYTE 8'h00
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_RELOAD 2'b10
`define MODE_SPLIT 2'b11
`define MAX_13BIT 13'h1FFF
`endif

// ==== pkg/dual_timer_pkg.sv ====
// Purpose: shared types of the dual counter/timer
// Assumes: constants live in dual_timer_params.svh
// Notes: none
package dual_timer_pkg;
	typedef enum logic [1:0] {
		MODE13 = 2'b00,
		MODE16 = 2'b01,
		MODE8R = 2'b10,
		MODESP = 2'b11
	} timer_mode_t;
	// register port request from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// interrupt vectoring acknowledges, one-cycle pulses
	typedef struct packed {
		logic timerOne;
		logic timerZero;
		logic extOne;
		logic extZero;
	} vector_ack_t;
endpackage : dual_timer_pkg

// ==== rtl/dual_counter_timer_control.sv ====
// Purpose: control, mode and count registers for two counter/timers and two external irq flags
// Assumes: one 50 MHz clock; tick enables come from the clock-control prescaler outside
// Notes: pins are synchronised by two flip-flops before use
`include "dual_timer_params.svh"

// Contract
// - timer one overflow sets bit 7 unless timer zero is split; software or vectoring clears it.
// - timer zero overflow sets bit 5; software or vectoring clears it.
// - writing 1 to bit 6 or bit 4 runs timer one or zero.
// - irq one edge/level sets bit 3; vectoring clears only in edge mode.
// - irq zero edge/level sets bit 1; vectoring clears only in edge mode.
// - irq one type bit: 0 level, 1 edge triggered.
// - irq zero type bit: 0 level, 1 edge triggered.
// - gated timer one counts only while irq one input active and run (or timer zero split).
// - gated timer zero counts only while run and irq zero input active.
// - timer one counts internal ticks, or falling pin edges when counter select set and timer zero not split.
// - timer zero counts internal ticks, or falling pin edges when counter select set.
// - timer one modes: 13-bit, 16-bit, 8-bit reload, inactive.
// - timer zero modes: 13-bit, 16-bit, 8-bit reload, split 8-bit pair.
// - timer zero low and high bytes are separate read/write, reset zero.
// - timer one low byte is read/write, reset zero.
// - 13-bit mode uses high byte and five low bits; overflow at 0x1FFF.
// - 16-bit mode wraps from all ones to zero and overflows.
// - reload mode: low byte wraps, flag set, low reloads from high.
// - split mode: zero high byte runs on ticks under timer one run, sets one flag.
module dual_counter_timer_control (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire dual_timer_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	// interrupt vectoring and prescaled ticks
	input wire dual_timer_pkg::vector_ack_t vecAck,
	input wire logic timerZeroTick,
	input wire logic timerOneTick,
	// external pins
	input wire logic timer_zero_count_pin,
	input wire logic timer_one_count_pin,
	input wire logic ext_irq_zero_input,
	input wire logic ext_irq_one_input,
	input wire logic ext_irq_zero_polarity,
	input wire logic ext_irq_one_polarity,
	// overflow strobes and request levels to the core
	output logic timerZeroOverflow,
	output logic timerOneOverflow,
	output logic [3:0] irqPending
);
	import dual_timer_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] timer_control_reg;
	logic [7:0] timer_mode_reg;
	logic [7:0] t0Low_reg;
	logic [7:0] t0High_reg;
	logic [7:0] t1Low_reg;
	logic [7:0] t1High_reg;
	logic [3:0] syncA_reg;
	logic [3:0] syncB_reg;
	logic [3:0] prev_reg;
	timer_mode_t mode0;
	timer_mode_t mode1;

	function automatic logic wrHit(input reg_req_t r, input logic [7:0] off);
		wrHit = r.wr && (r.addr == off);
	endfunction : wrHit

	assign mode0 = timer_mode_t'(timer_mode_reg[1:0]);
	assign mode1 = timer_mode_t'(timer_mode_reg[5:4]);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// order: {irq one, irq zero, pin one, pin zero}
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
			prev_reg <= 4'h0;
		end else begin
			syncA_reg <= {ext_irq_one_input, ext_irq_zero_input, timer_one_count_pin,
				timer_zero_count_pin};
			syncB_reg <= syncA_reg;
			prev_reg <= syncB_reg;
		end
	end

	logic pinFall0, pinFall1;
	logic irq0Active, irq1Active, irq0Edge, irq1Edge;
	assign pinFall0 = prev_reg[0] && !syncB_reg[0];
	assign pinFall1 = prev_reg[1] && !syncB_reg[1];
	// polarity 0 means active low
	assign irq0Active = syncB_reg[2] == ext_irq_zero_polarity;
	assign irq1Active = syncB_reg[3] == ext_irq_one_polarity;
	assign irq0Edge = irq0Active && (prev_reg[2] != ext_irq_zero_polarity);
	assign irq1Edge = irq1Active && (prev_reg[3] != ext_irq_one_polarity);

	// ----------------------------------------
	// count enables
	// ----------------------------------------
	logic run0, run1, en0, en1, enHigh0;
	logic tr0, tr1;
	assign tr0 = timer_control_reg[`BIT_TR0];
	assign tr1 = timer_control_reg[`BIT_TR1];
	assign run0 = tr0 && (!timer_mode_reg[`MOD_TIMER_ZERO_GATE_SELECT] || irq0Active);
	// in split mode timer one loses its run bit; mode alone keeps it running
	assign run1 = (mode0 == MODESP ? 1'b1 : tr1)
		&& (!timer_mode_reg[`MOD_TIMER_ONE_GATE_SELECT] || irq1Active);
	assign en0 = run0 && (timer_mode_reg[`MOD_CT0] ? pinFall0 : timerZeroTick);
	// split mode forbids external clocking of timer one
	assign en1 = run1 && (mode1 != MODESP) && ((timer_mode_reg[`MOD_CT1]
		&& mode0 != MODESP) ? pinFall1 : timerOneTick);
	assign enHigh0 = (mode0 == MODESP) && tr1 && timerOneTick;

	// ----------------------------------------
	// counter arithmetic
	// ----------------------------------------
	logic [7:0] t0LowNext, t0HighNext, t1LowNext, t1HighNext;
	logic ovf0, ovf1, ovfHigh0;

	always_comb begin
		t0LowNext = t0Low_reg;
		t0HighNext = t0High_reg;
		ovf0 = 1'b0;
		ovfHigh0 = 1'b0;
		if (en0) begin
			case (mode0)
				MODE13: begin
					ovf0 = {t0High_reg, t0Low_reg[4:0]} == `MAX_13BIT;
					t0LowNext = {t0Low_reg[7:5], t0Low_reg[4:0] + 5'h01};
					if (t0Low_reg[4:0] == 5'h1F) t0HighNext = t0High_reg + 8'h01;
				end
				MODE16: begin
					ovf0 = {t0High_reg, t0Low_reg} == 16'hFFFF;
					{t0HighNext, t0LowNext} = {t0High_reg, t0Low_reg} + 16'h0001;
				end
				MODE8R: begin
					ovf0 = t0Low_reg == 8'hFF;
					t0LowNext = ovf0 ? t0High_reg : t0Low_reg + 8'h01;
				end
				default: begin
					ovf0 = t0Low_reg == 8'hFF;
					t0LowNext = t0Low_reg + 8'h01;
				end
			endcase
		end
		if (enHigh0) begin
			ovfHigh0 = t0High_reg == 8'hFF;
			t0HighNext = t0High_reg + 8'h01;
		end
	end

	always_comb begin
		t1LowNext = t1Low_reg;
		t1HighNext = t1High_reg;
		ovf1 = 1'b0;
		if (en1) begin
			case (mode1)
				MODE13: begin
					ovf1 = {t1High_reg, t1Low_reg[4:0]} == `MAX_13BIT;
					t1LowNext = {t1Low_reg[7:5], t1Low_reg[4:0] + 5'h01};
					if (t1Low_reg[4:0] == 5'h1F) t1HighNext = t1High_reg + 8'h01;
				end
				MODE16: begin
					ovf1 = {t1High_reg, t1Low_reg} == 16'hFFFF;
					{t1HighNext, t1LowNext} = {t1High_reg, t1Low_reg} + 16'h0001;
				end
				MODE8R: begin
					ovf1 = t1Low_reg == 8'hFF;
					t1LowNext = ovf1 ? t1High_reg : t1Low_reg + 8'h01;
				end
				default: begin
					ovf1 = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// count bytes: a write wins over an increment
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			t0Low_reg <= `RESET_BYTE;
			t0High_reg <= `RESET_BYTE;
			t1Low_reg <= `RESET_BYTE;
			t1High_reg <= `RESET_BYTE;
		end else begin
			t0Low_reg <= wrHit(regReq, `OFF_T0_LOW) ? regReq.wdata : t0LowNext;
			t0High_reg <= wrHit(regReq, `OFF_T0_HIGH) ? regReq.wdata : t0HighNext;
			t1Low_reg <= wrHit(regReq, `OFF_T1_LOW) ? regReq.wdata : t1LowNext;
			t1High_reg <= wrHit(regReq, `OFF_T1_HIGH) ? regReq.wdata : t1HighNext;
		end
	end

	// ----------------------------------------
	// control and mode registers; hardware set beats clear
	// ----------------------------------------
	logic setTf1, setTf0, setIe1, setIe0;
	logic [7:0] ctrlBase;
	// with timer zero split, timer one cannot raise its own flag
	assign setTf1 = ovfHigh0 || (ovf1 && mode0 != MODESP);
	assign setTf0 = ovf0;
	assign setIe1 = timer_control_reg[`BIT_IT1] ? irq1Edge : irq1Active;
	assign setIe0 = timer_control_reg[`BIT_IT0] ? irq0Edge : irq0Active;

	always_comb begin
		ctrlBase = wrHit(regReq, `OFF_TIMER_CONTROL) ? regReq.wdata : timer_control_reg;
		if (vecAck.timerOne) ctrlBase[`BIT_TF1] = 1'b0;
		if (vecAck.timerZero) ctrlBase[`BIT_TF0] = 1'b0;
		if (vecAck.extOne && timer_control_reg[`BIT_IT1]) ctrlBase[`BIT_IE1] = 1'b0;
		if (vecAck.extZero && timer_control_reg[`BIT_IT0]) ctrlBase[`BIT_IE0] = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			timer_control_reg <= `RESET_BYTE;
		end else begin
			timer_control_reg <= ctrlBase | {setTf1, 1'b0, setTf0, 1'b0, setIe1, 1'b0, setIe0,
				1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			timer_mode_reg <= `RESET_BYTE;
		end else if (wrHit(regReq, `OFF_TIMER_MODE)) begin
			timer_mode_reg <= regReq.wdata;
		end
	end

	// ----------------------------------------
	// read port and strobes
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdata <= 8'h00;
		end else if (regReq.rd) begin
			case (regReq.addr)
				`OFF_TIMER_CONTROL: regRdata <= timer_control_reg;
				`OFF_TIMER_MODE: regRdata <= timer_mode_reg;
				`OFF_T0_LOW: regRdata <= t0Low_reg;
				`OFF_T1_LOW: regRdata <= t1Low_reg;
				`OFF_T0_HIGH: regRdata <= t0High_reg;
				`OFF_T1_HIGH: regRdata <= t1High_reg;
				default: regRdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			timerZeroOverflow <= 1'b0;
			timerOneOverflow <= 1'b0;
			irqPending <= 4'h0;
		end else begin
			timerZeroOverflow <= ovf0;
			// timer one overflow still pulses in split mode for baud use
			timerOneOverflow <= ovf1;
			irqPending <= {timer_control_reg[`BIT_TF1], timer_control_reg[`BIT_TF0],
				timer_control_reg[`BIT_IE1], timer_control_reg[`BIT_IE0]};
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_wrap16;
		en0 && mode0 == MODE16 && t0Low_reg == 8'hFF && t0High_reg == 8'hFF
			&& !wrHit(regReq, `OFF_T0_LOW) && !wrHit(regReq, `OFF_T0_HIGH);
	endsequence

	chk_tf0_on_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
		s_wrap16 |=> timer_control_reg[`BIT_TF0] && t0Low_reg == 8'h00 && t0High_reg == 8'h00)
		else $error("timer zero wrap did not set flag");
	chk_reload_value: assert property (@(posedge mclk) disable iff (!rst_n)
		en0 && mode0 == MODE8R && t0Low_reg == 8'hFF && !wrHit(regReq, `OFF_T0_LOW)
		&& !wrHit(regReq, `OFF_T0_HIGH) && !enHigh0
		|=> t0Low_reg == $past(t0High_reg) && t0High_reg == $past(t0High_reg))
		else $error("reload mode did not reload low byte");
	chk_tf1_vector_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		vecAck.timerOne && !setTf1 |=> !timer_control_reg[`BIT_TF1])
		else $error("vectoring did not clear timer one flag");
	chk_ie0_level_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		timer_control_reg[`BIT_IE0] && !timer_control_reg[`BIT_IT0] && vecAck.extZero
		&& !wrHit(regReq, `OFF_TIMER_CONTROL) |=> timer_control_reg[`BIT_IE0])
		else $error("level flag cleared by vectoring");
	chk_gate_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		timer_mode_reg[`MOD_TIMER_ZERO_GATE_SELECT] && !irq0Active && !wrHit(regReq, `OFF_T0_LOW)
		&& !wrHit(regReq, `OFF_T0_HIGH) && !enHigh0 |=> $stable(t0Low_reg))
		else $error("gated timer zero counted while inactive");
	chk_write_wins: assert property (@(posedge mclk) disable iff (!rst_n)
		wrHit(regReq, `OFF_T1_LOW) |=> t1Low_reg == $past(regReq.wdata))
		else $error("count byte write lost");
	chk_t1_inactive: assert property (@(posedge mclk) disable iff (!rst_n)
		mode1 == MODESP && !wrHit(regReq, `OFF_T1_LOW) |=> $stable(t1Low_reg))
		else $error("timer one counted while inactive");
	chk_pin_count_once: assert property (@(posedge mclk) disable iff (!rst_n)
		pinFall0 |=> !pinFall0)
		else $error("pin edge counted twice");
	chk_edge_sets_ie1: assert property (@(posedge mclk) disable iff (!rst_n)
		timer_control_reg[`BIT_IT1] && irq1Edge |=> timer_control_reg[`BIT_IE1])
		else $error("irq one edge lost");
	chk_split_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		enHigh0 && t0High_reg == 8'hFF |=> timer_control_reg[`BIT_TF1])
		else $error("split high byte overflow lost");
endmodule : dual_counter_timer_control

// ==== bench/far_side_model.sv ====
// Purpose: core-side prescaler ticks, count pins and irq inputs for the dual timer
// Assumes: everything changes just after the falling edge of mclk
// Notes: count pins idle high, so only commanded falls can count
module far_side_model (
	// clock
	input wire logic mclk,
	// prescaler ticks
	output logic tick0,
	output logic tick1,
	// external pins
	output logic pin0,
	output logic pin1,
	output logic irq0,
	output logic irq1
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{tick0, tick1, irq0, irq1} = 4'h0;
		{pin0, pin1} = 2'b11;
	end

	// --------------------------------
	// stimulus tasks
	// --------------------------------
	// one pulse every other cycle, so each pulse is a lone count
	task automatic ticks(input int n, input logic [1:0] which);
		repeat (n) begin
			@(negedge mclk) {tick1, tick0} = which;
			@(negedge mclk) {tick1, tick0} = 2'b00;
		end
	endtask : ticks

	// pins held four cycles each way to outlast the synchroniser
	task automatic falls(input int n, input logic which);
		repeat (n) begin
			@(negedge mclk) {pin1, pin0} = which ? 2'b01 : 2'b10;
			repeat (4) @(negedge mclk);
			{pin1, pin0} = 2'b11;
			repeat (4) @(negedge mclk);
		end
	endtask : falls

	task automatic setIrq(input logic v0, input logic v1);
		@(negedge mclk) {irq0, irq1} = {v0, v1};
	endtask : setIrq
endmodule : far_side_model

// ==== bench/dual_counter_timer_control_test.sv ====
// Purpose: self-checking bench for the dual counter/timer control block
// Assumes: irq polarities tied active high
// Notes: register accesses driven at the falling edge, read data taken one cycle later
`include "dual_timer_params.svh"
module dual_counter_timer_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dual_timer_pkg::*;

	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t regReq = '0;
	vector_ack_t vecAck = '0;
	logic [7:0] regRdata;
	logic [3:0] irqPending;
	logic tick0, tick1, pin0, pin1, irq0, irq1, ovf0, ovf1;
	int failures = 0;
	int num_checks = 0;
	int ovf0Seen = 0;
	int ovf1Seen = 0;

	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		if (ovf0 === 1'b1) ovf0Seen++;
		if (ovf1 === 1'b1) ovf1Seen++;
	end

	far_side_model far_side_model_i (.mclk(mclk), .tick0(tick0), .tick1(tick1),
		.pin0(pin0), .pin1(pin1), .irq0(irq0), .irq1(irq1));

	dual_counter_timer_control dual_counter_timer_control_i (.mclk(mclk), .rst_n(rst_n),
		.regReq(regReq), .regRdata(regRdata), .vecAck(vecAck),
		.timerZeroTick(tick0), .timerOneTick(tick1),
		.timer_zero_count_pin(pin0), .timer_one_count_pin(pin1),
		.ext_irq_zero_input(irq0), .ext_irq_one_input(irq1),
		.ext_irq_zero_polarity(1'b1), .ext_irq_one_polarity(1'b1),
		.timerZeroOverflow(ovf0), .timerOneOverflow(ovf1), .irqPending(irqPending));

	// --------------------------------
	// access tasks
	// --------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk) regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk) regReq = '0;
	endtask : wr

	task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk) regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk) regReq = '0;
		check(name, regRdata, exp);
	endtask : rdChk

	task automatic ack(input vector_ack_t v);
		@(negedge mclk) vecAck = v;
		@(negedge mclk) vecAck = '0;
	endtask : ack

	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		conclude();
	end

	initial begin
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		for (int a = 8'h88; a <= 8'h8D; a++) rdChk("reset", 8'(a), 8'h00);
		rdChk("unmapped", 8'h90, 8'h00);
		for (int a = 8'h8A; a <= 8'h8D; a++) wr(8'(a), 8'(a) ^ 8'hFF);
		for (int a = 8'h8A; a <= 8'h8D; a++) rdChk("count byte", 8'(a), 8'(a) ^ 8'hFF);
		// timer zero 16-bit wrap, then vectoring clears the flag
		wr(`OFF_TIMER_MODE, 8'h01);
		wr(`OFF_T0_LOW, 8'hFF);
		wr(`OFF_T0_HIGH, 8'hFF);
		wr(`OFF_TIMER_CONTROL, 8'h10);
		far_side_model_i.ticks(1, 2'b01);
		rdChk("t0 low 16", `OFF_T0_LOW, 8'h00);
		rdChk("t0 high 16", `OFF_T0_HIGH, 8'h00);
		rdChk("ctl tf0", `OFF_TIMER_CONTROL, 8'h30);
		check("pending", {4'h0, irqPending}, 8'h04);
		ack('{timerOne: 1'b0, timerZero: 1'b1, extOne: 1'b0, extZero: 1'b0});
		rdChk("ctl ack0", `OFF_TIMER_CONTROL, 8'h10);
		// 13-bit wrap from 0x1FFF
		wr(`OFF_TIMER_CONTROL, 8'h00);
		wr(`OFF_TIMER_MODE, 8'h00);
		wr(`OFF_T0_LOW, 8'h1F);
		wr(`OFF_T0_HIGH, 8'hFF);
		wr(`OFF_TIMER_CONTROL, 8'h10);
		far_side_model_i.ticks(1, 2'b01);
		rdChk("t0 low 13", `OFF_T0_LOW, 8'h00);
		rdChk("t0 high 13", `OFF_T0_HIGH, 8'h00);
		rdChk("ctl 13", `OFF_TIMER_CONTROL, 8'h30);
		// auto-reload keeps the high byte
		wr(`OFF_TIMER_CONTROL, 8'h00);
		rdChk("sw clear", `OFF_TIMER_CONTROL, 8'h00);
		wr(`OFF_TIMER_MODE, 8'h02);
		wr(`OFF_T0_HIGH, 8'h80);
		wr(`OFF_T0_LOW, 8'hFF);
		wr(`OFF_TIMER_CONTROL, 8'h10);
		far_side_model_i.ticks(4, 2'b01);
		rdChk("t0 reload", `OFF_T0_LOW, 8'h83);
		rdChk("th0 kept", `OFF_T0_HIGH, 8'h80);
		rdChk("ctl reload", `OFF_TIMER_CONTROL, 8'h30);
		check("ovf0 pulses", 8'(ovf0Seen), 8'h03);
		// gated pin counter, level-sensed irq zero
		wr(`OFF_TIMER_CONTROL, 8'h00);
		wr(`OFF_TIMER_MODE, 8'h0D);
		wr(`OFF_T0_LOW, 8'h00);
		wr(`OFF_TIMER_CONTROL, 8'h10);
		far_side_model_i.falls(3, 1'b0);
		rdChk("gate closed", `OFF_T0_LOW, 8'h00);
		far_side_model_i.setIrq(1'b1, 1'b0);
		repeat (4) @(negedge mclk);
		far_side_model_i.falls(3, 1'b0);
		far_side_model_i.ticks(2, 2'b01);
		rdChk("pin count", `OFF_T0_LOW, 8'h03);
		rdChk("level ie0", `OFF_TIMER_CONTROL, 8'h12);
		ack('{timerOne: 1'b0, timerZero: 1'b0, extOne: 1'b0, extZero: 1'b1});
		rdChk("level ack", `OFF_TIMER_CONTROL, 8'h12);
		far_side_model_i.setIrq(1'b0, 1'b0);
		repeat (4) @(negedge mclk);
		wr(`OFF_TIMER_CONTROL, 8'h00);
		rdChk("ie0 cleared", `OFF_TIMER_CONTROL, 8'h00);
		// edge-sensed irq one
		wr(`OFF_TIMER_CONTROL, 8'h04);
		far_side_model_i.setIrq(1'b0, 1'b1);
		repeat (4) @(negedge mclk);
		far_side_model_i.setIrq(1'b0, 1'b0);
		rdChk("edge ie1", `OFF_TIMER_CONTROL, 8'h0C);
		ack('{timerOne: 1'b0, timerZero: 1'b0, extOne: 1'b1, extZero: 1'b0});
		rdChk("edge ack", `OFF_TIMER_CONTROL, 8'h04);
		// timer one 16-bit wrap
		wr(`OFF_TIMER_MODE, 8'h10);
		wr(`OFF_T1_LOW, 8'hFF);
		wr(`OFF_T1_HIGH, 8'hFF);
		wr(`OFF_TIMER_CONTROL, 8'h40);
		far_side_model_i.ticks(1, 2'b10);
		rdChk("t1 low", `OFF_T1_LOW, 8'h00);
		rdChk("ctl tf1", `OFF_TIMER_CONTROL, 8'hC0);
		ack('{timerOne: 1'b1, timerZero: 1'b0, extOne: 1'b0, extZero: 1'b0});
		rdChk("ctl ack1", `OFF_TIMER_CONTROL, 8'h40);
		// timer one inactive, timer zero split under timer one run
		wr(`OFF_TIMER_MODE, 8'h33);
		wr(`OFF_T1_LOW, 8'h05);
		wr(`OFF_T0_HIGH, 8'hFF);
		far_side_model_i.ticks(1, 2'b11);
		rdChk("t1 idle", `OFF_T1_LOW, 8'h05);
		rdChk("split high", `OFF_T0_HIGH, 8'h00);
		rdChk("split tf1", `OFF_TIMER_CONTROL, 8'hC0);
		// the split high byte raises the flag only; timer one itself is idle, so no extra pulse
		check("ovf1 pulses", 8'(ovf1Seen), 8'h01);
		conclude();
	end
endmodule : dual_counter_timer_control_test
